// ===== scru_pkg.sv
package scru_pkg;
	// Register byte addresses
	localparam logic [7:0] SCRU_OUTCTL_ADDR = 8'h00;
	localparam logic [7:0] SCRU_LBCTL_ADDR = 8'h04;
	localparam logic [7:0] SCRU_SYSCTL_ADDR = 8'h08;
	localparam logic [7:0] SCRU_RSTWORD_ADDR = 8'h0c;
	localparam logic [7:0] SCRU_STAT_ADDR = 8'h10;

	// Values after reset
	localparam logic [2:0] SCRU_OUTCTL_RESET = 3'h0;
	localparam logic [1:0] SCRU_LBCTL_RESET = 2'h0;
	localparam logic [10:0] SCRU_SYSCTL_RESET = 11'h7ff;
	localparam logic [9:0] SCRU_RSTWORD_HARD = 10'h004;

	// Reset word field positions
	localparam int SCRU_SYSMULT_LSB = 0;
	localparam int SCRU_CORE_LSB = 4;
	localparam int SCRU_MEMMODE_BIT = 8;
	localparam int SCRU_LBMODE_BIT = 9;

	// System clock control field positions
	localparam int SCRU_SYSCTL_PCI_BIT = 10;
	localparam int SCRU_NUM_UNITS = 5;

	// Unit clock ratio encoding
	typedef enum logic [1:0] {
		SCRU_RATIO_OFF = 2'b00,
		SCRU_RATIO_FULL = 2'b01,
		SCRU_RATIO_HALF = 2'b10,
		SCRU_RATIO_THIRD = 2'b11
	} scru_ratio_t;

	// Local bus divide and system multiplier encoding
	localparam logic [1:0] SCRU_LDIV_2 = 2'b00;
	localparam logic [1:0] SCRU_LDIV_4 = 2'b01;
	localparam logic [3:0] SCRU_SYSMULT_X16 = 4'h0;
	localparam logic [3:0] SCRU_SYSMULT_RSVD = 4'h1;
endpackage : scru_pkg

// ===== scru_unit_gate.sv
`timescale 1ns/10ps
module scru_unit_gate
	import scru_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Ratio select
	input wire logic [1:0] ratio_i,
	// Gated unit clock tick
	output logic tick_o
);
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic [1:0] act_reg;

	// Period length minus one for a ratio
	function automatic logic [1:0] scru_last(input logic [1:0] r);
		case (r)
			SCRU_RATIO_HALF: scru_last = 2'h1;
			SCRU_RATIO_THIRD: scru_last = 2'h2;
			default: scru_last = 2'h0;
		endcase
	endfunction : scru_last

	always_comb begin
		cnt_next = (cnt_reg >= scru_last(act_reg)) ? 2'h0 : cnt_reg + 2'h1;
	end

	// New ratio taken only at a period end, so no short pulse appears
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			act_reg <= ratio_i;
			cnt_reg <= 2'h0;
		end else begin
			cnt_reg <= cnt_next;
			if (cnt_next == 2'h0) begin
				act_reg <= ratio_i; // [R16]
			end
		end
	end

	// Tick once per period, never while off
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= (cnt_next == 2'h0) && (act_reg != SCRU_RATIO_OFF)
				&& (ratio_i != SCRU_RATIO_OFF); // [R10] [R16]
		end
	end
endmodule : scru_unit_gate

// ===== scru_top.sv
`timescale 1ns/10ps
// How it works
// [R1] Primary clock comes from host input in host mode, else bus input.
// [R2] Host mode halves primary; strap picks full or half for sync out.
// [R3] Per-output select bit picks full or halved primary for each output.
// [R4] Board loops sync out back to sync in with matched delay.
// [R5] In agent mode the board grounds the unused host clock input.
// [R6] System ratio equals (1 + halving strap) times system multiplier.
// [R7] Core ratio from core field; fields from reset word or hard option.
// [R8] Memory ratio doubles with mode bit; pair is memory clock halved.
// [R9] Local unit ratio doubles with mode bit, then local divider drives outs.
// [R10] Units leave reset at default ratio, software may change or stop them.
// [R11] Five units default to third, pick off/full/half/third; bus unit off/full.
// [R12] Software keeps security and USB units under their frequency limit.
// [R13] Board picks input and multipliers keeping all clocks in range.
// [R14] System field 0000 means sixteen, 0001 reserved, else n.
// [R15] Local divider gives one half, one quarter or one eighth.
// [R16] Ratio changes and switch-off are glitch free.
module scru_top
	import scru_pkg::*;
#(
	parameter int NUM_BUS_OUTS = 3,
	parameter int NUM_LOCAL_OUTS = 3
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Straps and reset word
	input wire logic host_mode_strap_i,
	input wire logic input_halving_strap_i,
	input wire logic hard_reset_word_sel_i,
	input wire logic [9:0] reset_word_low_i,
	// Clock inputs, sampled as levels
	input wire logic host_primary_clock_in_i,
	input wire logic bus_clock_in_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Primary and bus clocks
	output logic primary_clock_o,
	output logic bus_sync_out_o,
	output logic [NUM_BUS_OUTS-1:0] bus_clock_out_n_o,
	// Derived ratios
	output logic [5:0] csb_ratio_o,
	output logic [3:0] core_multiplier_field_o,
	output logic [6:0] memory_ratio_o,
	output logic [6:0] localbus_ratio_o,
	// Memory and local bus clocks
	output logic memory_bus_clock_pair_p_o,
	output logic memory_bus_clock_pair_n_o,
	output logic localbus_sync_out_o,
	output logic [NUM_LOCAL_OUTS-1:0] localbus_clock_outs_o,
	// Unit clock ticks: eth1, eth2 and serial, security, usb dr, usb mph
	output logic [SCRU_NUM_UNITS-1:0] unit_tick_o,
	output logic pci_dma_tick_o,
	output logic sysmult_reserved_o
);
	logic [2:0] output_clock_control_reg;
	logic [1:0] localbus_clock_ctrl_reg;
	logic [10:0] system_clock_ctrl_reg;
	logic [9:0] reset_word_low_reg;
	logic host_reg;
	logic halving_reg;
	logic half_reg;
	logic [2:0] lcnt_reg;
	logic [2:0] lcnt_next;
	logic [1:0] ldiv_reg;
	logic lclk_reg;
	logic [5:0] csb_next;

	// System multiplier decode
	function automatic logic [4:0] scru_mult_decode(input logic [3:0] f);
		if (f == SCRU_SYSMULT_X16) begin
			scru_mult_decode = 5'h10; // [R14]
		end else if (f == SCRU_SYSMULT_RSVD) begin
			scru_mult_decode = 5'h00; // [R14]
		end else begin
			scru_mult_decode = {1'b0, f}; // [R14]
		end
	endfunction : scru_mult_decode

	// Last count of a half period of the local bus divider (half period length minus one)
	function automatic logic [2:0] scru_lhalf(input logic [1:0] d);
		case (d)
			SCRU_LDIV_2: scru_lhalf = 3'h0;
			SCRU_LDIV_4: scru_lhalf = 3'h1;
			default: scru_lhalf = 3'h3;
		endcase
	endfunction : scru_lhalf

	// Straps and reset word sampled while reset is low, held after
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			host_reg <= host_mode_strap_i;
			halving_reg <= input_halving_strap_i;
			reset_word_low_reg <= hard_reset_word_sel_i ? SCRU_RSTWORD_HARD
				: reset_word_low_i; // [R7]
		end
	end

	// Software registers
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			output_clock_control_reg <= SCRU_OUTCTL_RESET;
			localbus_clock_ctrl_reg <= SCRU_LBCTL_RESET;
			system_clock_ctrl_reg <= SCRU_SYSCTL_RESET; // [R11]
		end else if (wr_i) begin
			case (addr_i)
				SCRU_OUTCTL_ADDR: output_clock_control_reg <= wdata_i[2:0];
				SCRU_LBCTL_ADDR: localbus_clock_ctrl_reg <= wdata_i[1:0];
				SCRU_SYSCTL_ADDR: system_clock_ctrl_reg <= wdata_i[10:0]; // [R10]
				default: ;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i) begin
		if (!resetn_i || !rd_i) begin
			rdata_o <= 32'h0;
		end else begin
			case (addr_i)
				SCRU_OUTCTL_ADDR: rdata_o <= {29'h0, output_clock_control_reg};
				SCRU_LBCTL_ADDR: rdata_o <= {30'h0, localbus_clock_ctrl_reg};
				SCRU_SYSCTL_ADDR: rdata_o <= {21'h0, system_clock_ctrl_reg};
				SCRU_RSTWORD_ADDR: rdata_o <= {22'h0, reset_word_low_reg};
				SCRU_STAT_ADDR: rdata_o <= {24'h0, csb_ratio_o, halving_reg,
					host_reg};
				default: rdata_o <= 32'h0;
			endcase
		end
	end

	// Host input in host mode, bus input when agent
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			primary_clock_o <= 1'b0;
		end else begin
			primary_clock_o <= host_reg ? host_primary_clock_in_i
				: bus_clock_in_i; // [R1]
		end
	end

	// Divide by two stage; sync out and bus outs only driven as host
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			half_reg <= 1'b0;
			bus_sync_out_o <= 1'b0;
			bus_clock_out_n_o <= '0;
		end else begin
			half_reg <= ~half_reg; // [R2]
			bus_sync_out_o <= host_reg & (halving_reg ? ~half_reg : 1'b1); // [R2]
			for (int i = 0; i < NUM_BUS_OUTS; i++) begin
				bus_clock_out_n_o[i] <= host_reg
					& (output_clock_control_reg[i] ? ~half_reg : 1'b1); // [R3]
			end
		end
	end

	// Ratios to the sync input; sync input is looped back on the board
	always_comb begin
		csb_next = {1'b0,
			scru_mult_decode(reset_word_low_reg[SCRU_SYSMULT_LSB+:4])}
			<< halving_reg; // [R6] [R4]
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			csb_ratio_o <= 6'h0;
			core_multiplier_field_o <= 4'h0;
			memory_ratio_o <= 7'h0;
			localbus_ratio_o <= 7'h0;
			sysmult_reserved_o <= 1'b0;
		end else begin
			csb_ratio_o <= csb_next; // [R6]
			core_multiplier_field_o <= reset_word_low_reg[SCRU_CORE_LSB+:4]; // [R7]
			memory_ratio_o <= {1'b0, csb_next}
				<< reset_word_low_reg[SCRU_MEMMODE_BIT]; // [R8]
			localbus_ratio_o <= {1'b0, csb_next}
				<< reset_word_low_reg[SCRU_LBMODE_BIT]; // [R9]
			sysmult_reserved_o <= (reset_word_low_reg[SCRU_SYSMULT_LSB+:4]
				== SCRU_SYSMULT_RSVD); // [R14]
		end
	end

	// Memory bus pair: differential, half the controller clock
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			memory_bus_clock_pair_p_o <= 1'b0;
			memory_bus_clock_pair_n_o <= 1'b1;
		end else begin
			memory_bus_clock_pair_p_o <= ~memory_bus_clock_pair_p_o; // [R8]
			memory_bus_clock_pair_n_o <= memory_bus_clock_pair_p_o; // [R8]
		end
	end

	// Local divider; new divide only taken at a full period end
	always_comb begin
		lcnt_next = (lcnt_reg >= scru_lhalf(ldiv_reg)) ? 3'h0 : lcnt_reg + 3'h1;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			lcnt_reg <= 3'h0;
			ldiv_reg <= SCRU_LBCTL_RESET;
			lclk_reg <= 1'b0;
		end else begin
			lcnt_reg <= lcnt_next;
			if (lcnt_next == 3'h0) begin
				lclk_reg <= ~lclk_reg; // [R15]
				if (lclk_reg) begin
					ldiv_reg <= localbus_clock_ctrl_reg; // [R16]
				end
			end
		end
	end

	// Local outputs all follow the same divided clock
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			localbus_sync_out_o <= 1'b0;
			localbus_clock_outs_o <= '0;
		end else begin
			localbus_sync_out_o <= lcnt_next == 3'h0 ? ~lclk_reg : lclk_reg; // [R9]
			localbus_clock_outs_o <= {NUM_LOCAL_OUTS{lcnt_next == 3'h0
				? ~lclk_reg : lclk_reg}}; // [R9]
		end
	end

	// Per-unit gated clocks
	for (genvar u = 0; u < SCRU_NUM_UNITS; u++) begin : g_unit
		scru_unit_gate u_gate (
			.clk_i(clk_i),
			.resetn_i(resetn_i),
			.ratio_i(system_clock_ctrl_reg[2*u+:2]), // [R11]
			.tick_o(unit_tick_o[u])
		);
	end

	// Bus and copy complex: off or full only
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pci_dma_tick_o <= 1'b0;
		end else begin
			pci_dma_tick_o <= system_clock_ctrl_reg[SCRU_SYSCTL_PCI_BIT]; // [R11]
		end
	end
endmodule : scru_top

// ===== scru_top_props.sv
`timescale 1ns/10ps
module scru_top_props
	import scru_pkg::*;
(
	// Clock, reset, straps
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic host_mode_strap_i,
	input wire logic input_halving_strap_i,
	input wire logic hard_reset_word_sel_i,
	input wire logic [9:0] reset_word_low_i,
	input wire logic host_primary_clock_in_i,
	input wire logic bus_clock_in_i,
	// Watched outputs
	input wire logic primary_clock_o,
	input wire logic bus_sync_out_o,
	input wire logic [5:0] csb_ratio_o,
	input wire logic [3:0] core_multiplier_field_o,
	input wire logic [6:0] memory_ratio_o,
	input wire logic [6:0] localbus_ratio_o,
	input wire logic sysmult_reserved_o
);
	logic host_reg;
	logic halv_reg;
	logic ok;
	logic [9:0] w_reg;
	logic [1:0] up_reg;
	logic [5:0] c;
	// Straps held in reset; edge count hides the ratio pipeline
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			host_reg <= host_mode_strap_i;
			halv_reg <= input_halving_strap_i;
			w_reg <= hard_reset_word_sel_i ? SCRU_RSTWORD_HARD
				: reset_word_low_i;
			up_reg <= 2'h0;
		end else if (up_reg != 2'h3) begin
			up_reg <= up_reg + 2'h1;
		end
	end
	assign ok = up_reg == 2'h3;
	// Expected system ratio
	always_comb begin
		case (w_reg[3:0])
			SCRU_SYSMULT_X16: c = 6'h10;
			SCRU_SYSMULT_RSVD: c = 6'h00;
			default: c = {2'h0, w_reg[3:0]};
		endcase
		if (halv_reg) c = c << 1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_primary_mux: assert property (
		ok |-> primary_clock_o == (host_reg ?
		$past(host_primary_clock_in_i) : $past(bus_clock_in_i)))
		else $error("primary clock source wrong");
	a_sync_full: assert property (
		ok && host_reg && !halv_reg |-> bus_sync_out_o)
		else $error("sync out not full");
	a_sync_halved: assert property (
		ok && host_reg && halv_reg |-> bus_sync_out_o != $past(bus_sync_out_o))
		else $error("sync out not halved");
	a_system_ratio: assert property (ok |-> csb_ratio_o == c)
		else $error("system ratio wrong");
	a_memory_ratio: assert property (
		ok |-> memory_ratio_o == 7'(c) << w_reg[8])
		else $error("memory ratio wrong");
	a_local_ratio: assert property (
		ok |-> localbus_ratio_o == 7'(c) << w_reg[9])
		else $error("local ratio wrong");
	a_core_field: assert property (
		ok |-> core_multiplier_field_o == w_reg[7:4])
		else $error("core field wrong");
	a_reserved_flag: assert property (
		ok |-> sysmult_reserved_o == (w_reg[3:0] == SCRU_SYSMULT_RSVD))
		else $error("reserved flag wrong");
endmodule : scru_top_props

// ===== scru_board_model.sv
`timescale 1ns/10ps
module scru_board_model (
	// Clock and mode
	input wire logic clk_i,
	input wire logic host_mode_i,
	// Clocks offered to the block
	output logic host_clk_o,
	output logic bus_clk_o
);
	logic [1:0] div_reg = 2'h0;
	// Free running board oscillators, sync loop taken as ideal
	always_ff @(posedge clk_i) begin
		div_reg <= div_reg + 2'h1;
	end
	// Agent board grounds the unused host input
	assign host_clk_o = host_mode_i & div_reg[0];
	assign bus_clk_o = div_reg[1];
endmodule : scru_board_model

// ===== system_clock_ratio_unit_tb_top.sv
`timescale 1ns/10ps
module system_clock_ratio_unit_tb_top;
	import scru_pkg::*;
	logic clk_i = 1'b0, resetn_i = 1'b0, host_mode_strap_i = 1'b1;
	logic input_halving_strap_i = 1'b0, hard_reset_word_sel_i = 1'b0;
	logic [9:0] reset_word_low_i = 10'h000;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o, rd_val;
	logic wr_i = 1'b0, rd_i = 1'b0, host_primary_clock_in_i, bus_clock_in_i;
	logic primary_clock_o, bus_sync_out_o, memory_bus_clock_pair_p_o;
	logic memory_bus_clock_pair_n_o, localbus_sync_out_o, pci_dma_tick_o;
	logic sysmult_reserved_o;
	logic [2:0] bus_clock_out_n_o, localbus_clock_outs_o;
	logic [5:0] csb_ratio_o;
	logic [3:0] core_multiplier_field_o, cur, prev;
	logic [6:0] memory_ratio_o, localbus_ratio_o;
	logic [4:0] unit_tick_o;
	int err_total = 0, comparisons = 0, n [5];
	scru_top uut (.clk_i, .resetn_i, .host_mode_strap_i, .input_halving_strap_i,
		.hard_reset_word_sel_i, .reset_word_low_i, .host_primary_clock_in_i,
		.bus_clock_in_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.primary_clock_o, .bus_sync_out_o, .bus_clock_out_n_o, .csb_ratio_o,
		.core_multiplier_field_o, .memory_ratio_o, .localbus_ratio_o,
		.memory_bus_clock_pair_p_o, .memory_bus_clock_pair_n_o,
		.localbus_sync_out_o, .localbus_clock_outs_o, .unit_tick_o,
		.pci_dma_tick_o, .sysmult_reserved_o);
	scru_board_model board (.clk_i, .host_mode_i(host_mode_strap_i),
		.host_clk_o(host_primary_clock_in_i), .bus_clk_o(bus_clock_in_i));
	initial forever #5 clk_i = ~clk_i;
	task chk(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rd_val = rdata_o;
	endtask : rd
	// Reset with straps, then check every derived ratio
	task t_ratios(input logic h, v, s, input logic [9:0] w);
		logic [5:0] c;
		logic [9:0] e;
		@(posedge clk_i);
		resetn_i <= 1'b0;
		host_mode_strap_i <= h;
		input_halving_strap_i <= v;
		hard_reset_word_sel_i <= s;
		reset_word_low_i <= w;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1 e = s ? SCRU_RSTWORD_HARD : w;
		c = (e[3:0] == 4'h0) ? 6'h10 : (e[3:0] == 4'h1) ? 6'h0 : 6'(e[3:0]);
		c = c << v;
		chk("system", 32'(csb_ratio_o), 32'(c));
		chk("memory", 32'(memory_ratio_o), 32'(c) << e[8]);
		chk("local", 32'(localbus_ratio_o), 32'(c) << e[9]);
		chk("core", 32'(core_multiplier_field_o), 32'(e[7:4]));
		chk("reserved", 32'(sysmult_reserved_o), 32'(e[3:0] == 4'h1));
	endtask : t_ratios
	// Count unit ticks over 12 cycles; 12 divides every ratio evenly
	task t_ticks(input int exp_n);
		n = '{default: 0};
		repeat (12) begin
			@(posedge clk_i);
			#1;
			for (int i = 0; i < 5; i++) n[i] += int'(unit_tick_o[i]);
		end
		for (int i = 0; i < 5; i++) chk("ticks", n[i], exp_n);
	endtask : t_ticks
	// Same ratio in all five unit fields, bus unit bit on unless off, upper bits of the write ignored
	task t_units(input logic [1:0] r);
		wr(SCRU_SYSCTL_ADDR, 32'hfffff800 | 32'({|r, {5{r}}}));
		rd(SCRU_SYSCTL_ADDR);
		chk("system control", rd_val, 32'({|r, {5{r}}}));
		repeat (6) @(posedge clk_i);
		t_ticks((r == 2'h0) ? 0 : 12 / r);
		chk("dma tick", 32'(pci_dma_tick_o), 32'(|r));
	endtask : t_units
	// Toggles of sync out and bus outs (bit 3 is sync)
	task t_toggles(input logic [7:0] a, input logic [1:0] d, input int e [4]);
		wr(a, 32'(d));
		repeat (20) @(posedge clk_i);
		#1 prev = {bus_sync_out_o, bus_clock_out_n_o};
		if (a == SCRU_LBCTL_ADDR) prev = {4{localbus_sync_out_o}};
		n = '{default: 0};
		repeat (32) begin
			@(posedge clk_i);
			#1 cur = {bus_sync_out_o, bus_clock_out_n_o};
			if (a == SCRU_LBCTL_ADDR) cur = {4{localbus_sync_out_o}};
			for (int i = 0; i < 4; i++) n[i] += int'(cur[i] != prev[i]);
			prev = cur;
		end
		chk("local outs", 32'(localbus_clock_outs_o),
			32'({3{localbus_sync_out_o}}));
		for (int i = 0; i < 4; i++) chk("toggles", n[i], e[i]);
	endtask : t_toggles
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		report_and_stop();
	end
	initial begin
		t_ratios(1'b1, 1'b1, 1'b0, 10'h305);
		rd(SCRU_OUTCTL_ADDR);
		chk("output control", rd_val, 32'(SCRU_OUTCTL_RESET));
		rd(SCRU_LBCTL_ADDR);
		chk("local control", rd_val, 32'(SCRU_LBCTL_RESET));
		rd(8'h20);
		chk("unmapped", rd_val, 32'h0);
		wr(SCRU_RSTWORD_ADDR, 32'h0);
		rd(SCRU_RSTWORD_ADDR);
		chk("reset word", rd_val, 32'h305);
		rd(SCRU_STAT_ADDR);
		chk("status", rd_val, 32'h2b);
		chk("memory pair", 32'(memory_bus_clock_pair_p_o
			^ memory_bus_clock_pair_n_o), 32'h1);
		rd(SCRU_SYSCTL_ADDR);
		chk("control reset", rd_val, 32'h7ff);
		t_ticks(4);
		for (int r = 0; r < 4; r++) t_units(2'(r));
		t_units(2'h2);
		t_toggles(SCRU_OUTCTL_ADDR, 2'h1, '{32, 0, 0, 32});
		t_toggles(SCRU_OUTCTL_ADDR, 2'h0, '{0, 0, 0, 32});
		for (int d = 0; d < 4; d++)
			t_toggles(SCRU_LBCTL_ADDR, 2'(d), '{4{32 >> (d > 2 ? 2 : d)}});
		t_ratios(1'b0, 1'b0, 1'b0, 10'h0a0);
		t_ratios(1'b1, 1'b0, 1'b0, 10'h001);
		t_ratios(1'b1, 1'b1, 1'b1, 10'h3ff);
		report_and_stop();
	end
endmodule : system_clock_ratio_unit_tb_top
bind scru_top scru_top_props u_props (.clk_i, .resetn_i, .host_mode_strap_i,
	.input_halving_strap_i, .hard_reset_word_sel_i, .reset_word_low_i,
	.host_primary_clock_in_i, .bus_clock_in_i, .primary_clock_o,
	.bus_sync_out_o, .csb_ratio_o, .core_multiplier_field_o, .memory_ratio_o,
	.localbus_ratio_o, .sysmult_reserved_o);
